/* File: hdl/pmicp_i2c_port.sv */
// Function
// RULE1: Port works at any SCL rate up to 400 kHz; master keeps below.
// RULE2: General-call address is never acknowledged nor acted on.
// RULE3: During a read, only the master that started it is served; read_lock_r is set but gates nothing.
// RULE4: SDA only pulled low or released; SCL is input only.
// RULE5: Bits sampled on SCL rising edge; read data driven onto SDA.
// RULE6: Without select option, answer only to address 0x48.
// RULE7: Select-pin level changes decoded address on that variant.
// RULE8: Select pin replaces the power-good output on that variant.
// RULE9: Writing 1 to status bits in registers 12 and 14 clears them.
// RULE10: Subaddress byte selects the register for write and read data.
// RULE11: Reads or 0-writes keep fault flags; 1-write, disable, reset clear.
// RULE12: Fault flags sit in bits 5:0; alert implies one is set.
// RULE13: Read: write address, subaddress, repeated start, read, NACK, STOP.
// RULE14: Write: address, subaddress, data, each acknowledged, then STOP.
`include "pmicp_params.svh"

module pmicp_i2c_port #(
    parameter bit ADDR_SEL_FITTED = 1'b0
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // I2C pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Shared pin 20: address select in, power-good out
    input  wire logic       address_select_pin,
    input  wire logic       power_good_level,
    output logic            power_good_output,
    output logic            power_good_oe,
    // Device status inputs
    input  wire logic [5:0] fault_events,
    input  wire logic [7:0] latch_events,
    input  wire logic [7:0] status_live,
    input  wire logic       all_channels_off,
    // Control outputs
    output logic [7:0]      reg_view [`PMICP_NUM_REGS],
    output logic            fault_alert_n
);
    logic scl_s;
    logic sda_s;
    logic sel_s;
    logic scl_d_r;
    logic sda_d_r;

    pmicp_sync u_sync_scl (.clk(clk), .sys_rst(sys_rst), .async_in(scl_in), .sync_out(scl_s));
    pmicp_sync u_sync_sda (.clk(clk), .sys_rst(sys_rst), .async_in(sda_in), .sync_out(sda_s));
    pmicp_sync u_sync_sel (.clk(clk), .sys_rst(sys_rst),
                           .async_in(address_select_pin), .sync_out(sel_s));

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    // Edge and condition decode
    wire scl_rise  = scl_s & ~scl_d_r;                 // RULE5
    wire scl_fall  = ~scl_s & scl_d_r;
    wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
    wire stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // Address decode
    wire [6:0] own_addr = (ADDR_SEL_FITTED && sel_s) ? `PMICP_ADDR_ALT
                                                     : `PMICP_ADDR_DEFAULT; // RULE6 RULE7

    // Shared pin: output only when the select option is absent
    assign power_good_output = 1'b0;                    // RULE8
    assign power_good_oe     = !ADDR_SEL_FITTED && !power_good_level; // RULE8

    pmicp_pkg::pmicp_state_t state_r, state_nxt;
    logic [7:0]              shift_r;
    logic [3:0]              bitcnt_r;
    logic                    rw_r;
    logic                    have_sub_r;
    logic                    read_lock_r;
    logic                    sda_low_r;
    logic [`PMICP_REG_AW-1:0] sub_r;
    logic [7:0]              regs_r [`PMICP_NUM_REGS];
    logic [5:0]              fault_r;
    logic [7:0]              latch_r;

    wire [7:0] shift_in    = {shift_r[6:0], sda_s};
    wire       byte_done   = scl_rise && (bitcnt_r == 4'd7);
    wire       addr_match  = (shift_in[7:1] == own_addr) &&
                             (shift_in[7:1] != `PMICP_GCALL_ADDR); // RULE2 RULE6
    wire       wr_strobe   = (state_r == pmicp_pkg::ST_RX) && byte_done && have_sub_r; // RULE14
    wire       master_ack  = ~sda_s;

    // Read data mux
    wire [7:0] rd_data = (sub_r == `PMICP_REG_FAULT)     ? {2'b00, fault_r} :
                         (sub_r == `PMICP_REG_LATCH)     ? latch_r :
                         (sub_r == `PMICP_REG_STATUS_RD) ? status_live :
                         regs_r[sub_r];                     // RULE10

    // Fault flags: set wins over a write-1 clear
    wire [5:0] fault_clr = (wr_strobe && sub_r == `PMICP_REG_FAULT) ? shift_in[5:0] : 6'h00;
    wire [7:0] latch_clr = (wr_strobe && sub_r == `PMICP_REG_LATCH) ? shift_in : 8'h00;

    always_ff @(posedge clk) begin
        if (sys_rst || all_channels_off) begin
            fault_r <= 6'h00;                                     // RULE11
        end else begin
            fault_r <= (fault_r & ~fault_clr) | fault_events;     // RULE9 RULE11
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            latch_r <= 8'h00;
        end else begin
            latch_r <= (latch_r & ~latch_clr) | latch_events;     // RULE9
        end
    end

    assign fault_alert_n = ~|(fault_r & regs_r[`PMICP_REG_FAULT_MASK][5:0]); // RULE12

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int i = 0; i < `PMICP_NUM_REGS; i++) begin
                regs_r[i] <= `PMICP_REG_RESET;
            end
        end else if (wr_strobe) begin
            regs_r[sub_r] <= shift_in;                            // RULE10
        end
    end

    always_comb begin
        reg_view = regs_r;
    end

    // Protocol state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            pmicp_pkg::ST_IDLE:     state_nxt = pmicp_pkg::ST_IDLE;
            pmicp_pkg::ST_ADDR: begin
                if (byte_done) begin
                    state_nxt = addr_match ? pmicp_pkg::ST_ADDR_ACK : pmicp_pkg::ST_IDLE;
                end
            end
            pmicp_pkg::ST_ADDR_ACK: begin
                // Leave on the fall that ends the ack clock, not the one that starts it
                if (scl_fall && sda_low_r) begin
                    state_nxt = rw_r ? pmicp_pkg::ST_TX : pmicp_pkg::ST_RX;
                end
            end
            pmicp_pkg::ST_RX: begin
                if (byte_done) begin
                    state_nxt = pmicp_pkg::ST_RX_ACK;
                end
            end
            pmicp_pkg::ST_RX_ACK: begin
                if (scl_fall && sda_low_r) begin
                    state_nxt = pmicp_pkg::ST_RX;
                end
            end
            pmicp_pkg::ST_TX: begin
                if (scl_fall && bitcnt_r == 4'd7) begin
                    state_nxt = pmicp_pkg::ST_TX_ACK;
                end
            end
            pmicp_pkg::ST_TX_ACK: begin
                // Next byte starts only after SCL falls, so SDA never moves while high
                if (scl_rise && !master_ack) begin
                    state_nxt = pmicp_pkg::ST_IDLE;                  // RULE13
                end else if (scl_fall) begin
                    state_nxt = pmicp_pkg::ST_TX;
                end
            end
            default:                state_nxt = pmicp_pkg::ST_IDLE;
        endcase
        if (start_det) begin
            state_nxt = pmicp_pkg::ST_ADDR;
        end
        if (stop_det) begin
            state_nxt = pmicp_pkg::ST_IDLE;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_r <= pmicp_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Read lock: held from read-address ack until STOP
    always_ff @(posedge clk) begin
        if (sys_rst || stop_det) begin
            read_lock_r <= 1'b0;
        end else if (state_r == pmicp_pkg::ST_ADDR && byte_done && addr_match && shift_in[0]) begin
            read_lock_r <= 1'b1;                                  // RULE3
        end
    end

    // Bit counter and shifter
    always_ff @(posedge clk) begin
        if (sys_rst || start_det) begin
            bitcnt_r <= 4'd0;
            shift_r  <= 8'h00;
        end else if (state_r == pmicp_pkg::ST_TX) begin
            if (state_nxt == pmicp_pkg::ST_TX_ACK) begin
                bitcnt_r <= 4'd0;
            end else if (scl_fall) begin
                shift_r  <= {shift_r[6:0], 1'b1};
                bitcnt_r <= bitcnt_r + 4'd1;
            end
        end else if (state_nxt == pmicp_pkg::ST_TX && state_r != pmicp_pkg::ST_TX) begin
            // Bit 7 goes out on entry; keep the remaining bits
            shift_r  <= {rd_data[6:0], 1'b1};                     // RULE5
            bitcnt_r <= 4'd0;
        end else if (scl_rise && (state_r == pmicp_pkg::ST_ADDR || state_r == pmicp_pkg::ST_RX)) begin
            shift_r  <= shift_in;                                 // RULE5
            bitcnt_r <= (bitcnt_r == 4'd7) ? 4'd0 : bitcnt_r + 4'd1;
        end
    end

    // Direction, subaddress capture
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rw_r       <= 1'b0;
            have_sub_r <= 1'b0;
            sub_r      <= '0;
        end else if (state_r == pmicp_pkg::ST_ADDR && byte_done) begin
            rw_r <= shift_in[0];
            if (!shift_in[0]) begin
                have_sub_r <= 1'b0;
            end
        end else if (state_r == pmicp_pkg::ST_RX && byte_done && !have_sub_r) begin
            sub_r      <= shift_in[`PMICP_REG_AW-1:0];            // RULE10 RULE14
            have_sub_r <= 1'b1;
        end
    end

    // SDA drive: ack low, data low bits; never driven high
    always_ff @(posedge clk) begin
        if (sys_rst || stop_det || start_det) begin
            sda_low_r <= 1'b0;
        end else if (scl_fall) begin
            case (state_r)
                pmicp_pkg::ST_ADDR_ACK: sda_low_r <= sda_low_r ? (rw_r && !rd_data[7]) : 1'b1;
                pmicp_pkg::ST_RX_ACK:   sda_low_r <= ~sda_low_r;  // RULE14
                pmicp_pkg::ST_TX:       sda_low_r <= (bitcnt_r != 4'd7) && !shift_r[7];
                pmicp_pkg::ST_TX_ACK:   sda_low_r <= !rd_data[7]; // RULE5
                default:              sda_low_r <= 1'b0;
            endcase
        end else if (byte_done && (state_r == pmicp_pkg::ST_RX ||
                     (state_r == pmicp_pkg::ST_ADDR && addr_match))) begin
            sda_low_r <= 1'b0;
        end
    end

    assign sda_out = 1'b0;                                        // RULE4
    assign sda_oe  = sda_low_r;                                   // RULE4
endmodule

/* File: hdl/pmicp_params.svh */
`ifndef PMICP_PARAMS_SVH
`define PMICP_PARAMS_SVH

// Target address, 7 bits, and the alternative picked by the select pin
`define PMICP_ADDR_DEFAULT   7'h48
`define PMICP_ADDR_ALT       7'h49
`define PMICP_GCALL_ADDR     7'h00
// Register file
`define PMICP_NUM_REGS       32
`define PMICP_REG_AW         5
`define PMICP_REG_LATCH      5'h0C
`define PMICP_REG_STATUS_RD  5'h0D
`define PMICP_REG_FAULT      5'h0E
`define PMICP_REG_FAULT_MASK 5'h0F
`define PMICP_FAULT_BITS     6
`define PMICP_REG_RESET      8'h00
// Link speed
`define PMICP_SCL_MAX_KHZ    400
`define PMICP_CLK_MHZ        100

`endif

/* File: hdl/pmicp_pkg.sv */
package pmicp_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_RX,
        ST_RX_ACK,
        ST_TX,
        ST_TX_ACK
    } pmicp_state_t;
endpackage

/* File: hdl/pmicp_sync.sv */
module pmicp_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic sys_rst,
    // Asynchronous level in, synchronised level out
    input  wire logic async_in,
    output logic      sync_out
);
    logic meta_r;
    logic sync_r;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            meta_r <= 1'b1;
            sync_r <= 1'b1;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;
endmodule

/* File: testbench/pmicp_chk.sv */
`include "pmicp_params.svh"

module pmicp_chk #(
    parameter bit ADDR_SEL_FITTED = 1'b0
) (
    // Clock
    input wire logic       clk,
    input wire logic       sys_rst,
    // Pins
    input wire logic       scl_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       power_good_level,
    input wire logic       power_good_output,
    input wire logic       power_good_oe,
    // Status
    input wire logic       all_channels_off,
    input wire logic [7:0] reg_view [`PMICP_NUM_REGS],
    input wire logic       fault_alert_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_sda_low; sda_oe |-> !sda_out; endproperty
    a_sda_low: assert property (p_sda_low) else $error("sda driven high");
    property p_pg_drain; power_good_oe |-> !power_good_output; endproperty
    a_pg_drain: assert property (p_pg_drain) else $error("pg driven high");
    property p_pg_on; !power_good_level [*6] |-> power_good_oe == !ADDR_SEL_FITTED; endproperty
    a_pg_on: assert property (p_pg_on) else $error("pg not pulled");
    property p_pg_off; power_good_level [*6] |-> !power_good_oe; endproperty
    a_pg_off: assert property (p_pg_off) else $error("pg pulled");
    // Sync delay is 2 clocks, 3 to sda_oe, so 6 high samples are well past any fall
    property p_hold; scl_in [*6] |-> $stable(sda_oe); endproperty
    a_hold: assert property (p_hold) else $error("sda moved, scl high");
    property p_oe_rise; $rose(sda_oe) |-> !scl_in; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("drive began, scl high");
    property p_oe_fall; $fell(sda_oe) |-> !scl_in; endproperty
    a_oe_fall: assert property (p_oe_fall) else $error("release, scl high");
    property p_alert; !fault_alert_n |-> reg_view[`PMICP_REG_FAULT_MASK] != 8'h00; endproperty
    a_alert: assert property (p_alert) else $error("alert with no mask");
    property p_clear; all_channels_off |-> ##[1:3] fault_alert_n; endproperty
    a_clear: assert property (p_clear) else $error("alert kept");
    property p_rst; disable iff (1'b0) sys_rst |=> !sda_oe && fault_alert_n; endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");

    c_ack: cover property ($rose(sda_oe));
    c_alert: cover property ($fell(fault_alert_n));
    c_off: cover property (all_channels_off);
endmodule

bind pmicp_i2c_port pmicp_chk #(.ADDR_SEL_FITTED(ADDR_SEL_FITTED)) i_chk (
    .clk, .sys_rst, .scl_in, .sda_out, .sda_oe, .power_good_level, .power_good_output,
    .power_good_oe, .all_channels_off, .reg_view, .fault_alert_n
);

/* File: testbench/pmicp_host_model.sv */
module pmicp_host_model (
    // Clock
    input  wire logic clk,
    // Bus lines
    input  wire logic sda,
    output logic      scl,
    output logic      sda_oe_m
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_oe_m = 1'b0;
    end
    // Four quarters of 63 clocks keep SCL under 400 kHz
    task automatic wq;
        repeat (63) @(negedge clk);
    endtask
    task automatic xfer(input logic b, output logic r);
        sda_oe_m = !b;
        wq;
        scl = 1'b1;
        wq;
        r = sda;
        wq;
        scl = 1'b0;
        wq;
    endtask
    task automatic start;
        sda_oe_m = 1'b0;
        wq;
        scl = 1'b1;
        wq;
        sda_oe_m = 1'b1;
        wq;
        scl = 1'b0;
        wq;
    endtask
    task automatic stop;
        sda_oe_m = 1'b1;
        wq;
        scl = 1'b1;
        wq;
        sda_oe_m = 1'b0;
        wq;
    endtask
    task automatic put(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) xfer(d[i], r);
        xfer(1'b1, r);
        ack = !r;
    endtask
    task automatic get(output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer(1'b1, r);
            d[i] = r;
        end
        xfer(1'b1, r);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] s, d, output logic ok);
        logic k1, k2, k3;
        start;
        put({a, 1'b0}, k1);
        // A refused address ends the transfer at once
        if (k1) put(s, k2);
        if (k1) put(d, k3);
        stop;
        ok = k1 && k2 && k3;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] s, output logic [7:0] d);
        logic k;
        start;
        put({a, 1'b0}, k);
        put(s, k);
        start;
        put({a, 1'b1}, k);
        get(d);
        stop;
    endtask
endmodule

/* File: testbench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;
    logic       sys_rst;
    logic       pg_lvl;
    logic       all_off;
    logic [5:0] f_ev;
    logic [7:0] l_ev;
    logic [7:0] st_live;
    logic       sda_oe;
    logic       pg_oe;
    logic       alert_n;
    logic [7:0] rv [32];
    logic       m_scl;
    logic       m_oe;
    logic       ok;
    logic [7:0] d;
    logic [7:0] s;
    int         ref_r [32];
    int         error_cnt = 0;
    int         num_checks = 0;
    wire        sda = ~(sda_oe | m_oe);

    pmicp_i2c_port i_dut (
        .clk, .sys_rst, .scl_in(m_scl), .sda_in(sda), .sda_out(), .sda_oe,
        .address_select_pin(~pg_oe), .power_good_level(pg_lvl), .power_good_output(),
        .power_good_oe(pg_oe), .fault_events(f_ev), .latch_events(l_ev),
        .status_live(st_live), .all_channels_off(all_off), .reg_view(rv),
        .fault_alert_n(alert_n)
    );
    pmicp_host_model i_host (.clk, .sda, .scl(m_scl), .sda_oe_m(m_oe));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Traffic needs about 81k cycles
    initial begin
        #1ms;
        error_cnt++;
        results;
    end
    initial begin
        sys_rst = 1'b1;
        pg_lvl = 1'b0;
        all_off = 1'b0;
        f_ev = 6'h00;
        l_ev = 8'h00;
        void'($urandom(32'h1C90));
        st_live = 8'($urandom);
        foreach (ref_r[i]) ref_r[i] = 0;
        repeat (3) @(negedge clk);
        sys_rst = 1'b0;
        repeat (8) @(negedge clk);
        chk(alert_n, 1'b1);
        chk(pg_oe, 1'b1);
        // Upper subaddress bits random to exercise the wrap
        s = {3'($urandom), 5'($urandom_range(0, 11))};
        d = 8'($urandom);
        i_host.wr(7'h48, s, d, ok);
        ref_r[s[4:0]] = d;
        chk(ok, 1'b1);
        chk(rv[s[4:0]], 8'(ref_r[s[4:0]]));
        i_host.rd(7'h48, s, d);
        chk(d, 8'(ref_r[s[4:0]]));
        for (int k = 0; k < 2; k++) begin
            i_host.wr(k ? 7'h00 : 7'h49, s, ~d, ok);
            chk(ok, 1'b0);
            chk(rv[s[4:0]], 8'(ref_r[s[4:0]]));
        end
        f_ev = 6'h3F;
        l_ev = 8'hFF;
        @(negedge clk);
        f_ev = 6'h00;
        l_ev = 8'h00;
        i_host.rd(7'h48, 8'h0E, d);
        chk(d, 8'h3F);
        i_host.wr(7'h48, 8'h0E, 8'h00, ok);
        i_host.wr(7'h48, 8'h0E, 8'h02, ok);
        i_host.rd(7'h48, 8'h0E, d);
        chk(d, 8'h3D);
        i_host.wr(7'h48, 8'h0F, 8'h04, ok);
        repeat (3) @(negedge clk);
        chk(alert_n, 1'b0);
        all_off = 1'b1;
        pg_lvl = 1'b1;
        repeat (3) @(negedge clk);
        all_off = 1'b0;
        chk(alert_n, 1'b1);
        i_host.wr(7'h48, 8'h0C, 8'h01, ok);
        i_host.rd(7'h48, 8'h0C, d);
        chk(d, 8'hFE);
        chk(pg_oe, 1'b0);
        results;
    end
endmodule
